// file: logic/sbx_addr.sv
// operand address resolution for the file-register subtract
`default_nettype none
module sbx_addr
    import sbx_pkg::*;
(
    // instruction fields and extended-set enable
    input wire logic [7:0] f_addr,
    input wire logic bank_a,
    input wire logic ext_en,
    // banking state
    input wire logic [3:0] bank_select_reg,
    input wire logic [11:0] index_base,
    // resolved address
    output logic [11:0] phys_addr
);
    always_comb begin
        if (bank_a) begin
            phys_addr = {bank_select_reg, f_addr}; // RULE_06
        end else if (ext_en && (f_addr <= SBX_IDX_LIMIT)) begin
            phys_addr = index_base + {4'h0, f_addr}; // RULE_07
        end else if (f_addr < SBX_ACC_SPLIT) begin
            phys_addr = {4'h0, f_addr}; // RULE_05
        end else begin
            phys_addr = {SBX_SFR_BANK, f_addr}; // RULE_05
        end
    end
endmodule
`default_nettype wire

// file: logic/sbx_alu.sv
// eight-bit subtractor with status flag generation
`default_nettype none
module sbx_alu
    import sbx_pkg::*;
(
    // operands: result is minuend minus subtrahend
    input wire logic [7:0] minuend,
    input wire logic [7:0] subtrahend,
    // result and flags
    output logic [7:0] diff,
    output logic [4:0] flags
);
    logic [8:0] full;
    logic [4:0] low;
    always_comb begin
        full = {1'b0, minuend} + {1'b0, ~subtrahend} + 9'h001; // RULE_02
        low = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} + 5'h01;
        diff = full[7:0];
        flags = SBX_RST_FLAGS;
        flags[SBX_ST_C_BIT] = full[8]; // RULE_09
        flags[SBX_ST_HALF_BIT] = low[4]; // RULE_09
        flags[SBX_ST_Z_BIT] = (full[7:0] == 8'h00); // RULE_08
        flags[SBX_ST_OVF_BIT] = (minuend[7] != subtrahend[7]) && (full[7] != minuend[7]); // RULE_08
        flags[SBX_ST_N_BIT] = full[7]; // RULE_08
    end
endmodule
`default_nettype wire

// file: logic/sbx_core.sv
// top of the subtract instruction datapath with data memory
`default_nettype none
module sbx_core
    import sbx_pkg::*;
#(
    parameter int MEM_DEPTH = 4096
)(
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // status
    output logic busy_ff
);
    // ---------------------------------------------------------------
    // storage
    // ---------------------------------------------------------------
    logic [7:0] mem [MEM_DEPTH];
    logic [7:0] acc_ff;
    logic [3:0] bank_select_reg;
    logic [11:0] idx_base_ff;
    logic ext_en_ff;
    logic [7:0] lit_ff;
    logic [7:0] fadr_ff;
    logic [11:0] mema_ff;
    logic [4:0] flags_ff;
    logic [7:0] opnd_ff;
    logic op_file_ff;
    logic dest_ff;
    logic bank_ff;
    logic [11:0] phys_ff;
    sbx_state_e state_ff;
    sbx_state_e nxt_state;
    logic [11:0] phys_addr;
    logic [7:0] diff;
    logic [4:0] alu_flags;
    logic start;
    logic cpu_mem_wr;
    logic [7:0] nxt_rdata;

    assign start = reg_wr && (reg_addr == SBX_ADDR_CMD) && (state_ff == SBX_IDLE);
    // ---------------------------------------------------------------
    // operand address and arithmetic
    // ---------------------------------------------------------------
    sbx_addr u_addr (
        .f_addr(fadr_ff),
        .bank_a(bank_ff),
        .ext_en(ext_en_ff),
        .bank_select_reg(bank_select_reg),
        .index_base(idx_base_ff),
        .phys_addr(phys_addr)
    );
    sbx_alu u_alu (
        .minuend(op_file_ff ? opnd_ff : lit_ff), // RULE_01
        .subtrahend(acc_ff),
        .diff(diff),
        .flags(alu_flags)
    );
    // ---------------------------------------------------------------
    // sequencer: idle, read operand, write result
    // ---------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            SBX_IDLE: begin
                if (start) begin
                    nxt_state = reg_wdata[SBX_CMD_OP_BIT] ? SBX_READ : SBX_WRITE;
                end
            end
            SBX_READ: nxt_state = SBX_WRITE;
            SBX_WRITE: nxt_state = SBX_IDLE;
            default: nxt_state = SBX_IDLE;
        endcase
    end
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state_ff <= SBX_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            busy_ff <= 1'b0;
        end else begin
            busy_ff <= (nxt_state != SBX_IDLE);
        end
    end
    // ---------------------------------------------------------------
    // latched instruction fields
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            op_file_ff <= 1'b0;
            dest_ff <= 1'b1;
            bank_ff <= 1'b1;
        end else if (start) begin
            op_file_ff <= reg_wdata[SBX_CMD_OP_BIT];
            dest_ff <= reg_wdata[SBX_CMD_D_BIT];
            bank_ff <= reg_wdata[SBX_CMD_A_BIT];
        end
    end
    // operand fetch; address held so the write-back hits the same cell
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            opnd_ff <= SBX_RST_BYTE;
            phys_ff <= SBX_RST_ADDR;
        end else if (state_ff == SBX_READ) begin
            opnd_ff <= mem[phys_addr[$clog2(MEM_DEPTH)-1:0]]; // RULE_02
            phys_ff <= phys_addr;
        end
    end
    // ---------------------------------------------------------------
    // software-visible registers
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ext_en_ff <= 1'b0;
            bank_select_reg <= SBX_RST_BANK;
            idx_base_ff <= SBX_RST_ADDR;
            lit_ff <= SBX_RST_BYTE;
            fadr_ff <= SBX_RST_BYTE;
            mema_ff <= SBX_RST_ADDR;
        end else if (reg_wr && (state_ff == SBX_IDLE)) begin
            case (reg_addr)
                SBX_ADDR_CTRL: ext_en_ff <= reg_wdata[SBX_CTRL_EXT_BIT];
                SBX_ADDR_BANK: bank_select_reg <= reg_wdata[3:0];
                SBX_ADDR_IDX: idx_base_ff <= {4'h0, reg_wdata};
                SBX_ADDR_LIT: lit_ff <= reg_wdata;
                SBX_ADDR_FADR: fadr_ff <= reg_wdata;
                SBX_ADDR_MEMA: mema_ff <= {bank_select_reg, reg_wdata};
                default: begin
                end
            endcase
        end
    end
    // accumulator: software load or instruction result
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            acc_ff <= SBX_RST_BYTE;
        end else if (state_ff == SBX_WRITE) begin
            if (!op_file_ff || !dest_ff) begin
                acc_ff <= diff; // RULE_01 RULE_03
            end
        end else if (reg_wr && (reg_addr == SBX_ADDR_ACC) && (state_ff == SBX_IDLE)) begin
            acc_ff <= reg_wdata;
        end
    end
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            flags_ff <= SBX_RST_FLAGS;
        end else if (state_ff == SBX_WRITE) begin
            flags_ff <= alu_flags; // RULE_08
        end
    end
    // ---------------------------------------------------------------
    // data memory: no reset, it models register file contents
    // ---------------------------------------------------------------
    assign cpu_mem_wr = reg_wr && (reg_addr == SBX_ADDR_MEMD) && (state_ff == SBX_IDLE);
    always_ff @(posedge sys_clk) begin
        if ((state_ff == SBX_WRITE) && op_file_ff && dest_ff) begin
            mem[phys_ff[$clog2(MEM_DEPTH)-1:0]] <= diff; // RULE_04
        end else if (cpu_mem_wr) begin
            mem[mema_ff[$clog2(MEM_DEPTH)-1:0]] <= reg_wdata;
        end
    end
    // ---------------------------------------------------------------
    // read port, data one cycle after the strobe
    // ---------------------------------------------------------------
    always_comb begin
        case (reg_addr)
            SBX_ADDR_CTRL: nxt_rdata = {7'h00, ext_en_ff};
            SBX_ADDR_ACC: nxt_rdata = acc_ff;
            SBX_ADDR_BANK: nxt_rdata = {4'h0, bank_select_reg};
            SBX_ADDR_IDX: nxt_rdata = idx_base_ff[7:0];
            SBX_ADDR_LIT: nxt_rdata = lit_ff;
            SBX_ADDR_FADR: nxt_rdata = fadr_ff;
            SBX_ADDR_CMD: nxt_rdata = {5'h00, bank_ff, dest_ff, op_file_ff};
            SBX_ADDR_STAT: nxt_rdata = {2'h0, busy_ff, flags_ff};
            SBX_ADDR_MEMD: nxt_rdata = mem[mema_ff[$clog2(MEM_DEPTH)-1:0]];
            SBX_ADDR_MEMA: nxt_rdata = mema_ff[7:0];
            default: nxt_rdata = 8'h00;
        endcase
    end
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= SBX_RST_BYTE;
        end else if (reg_rd) begin
            reg_rdata <= nxt_rdata;
        end else begin
            reg_rdata <= 8'h00;
        end
    end
endmodule
`default_nettype wire

// file: logic/sbx_pkg.sv
// constants and types for the subtract instruction datapath
// How it works
// RULE_01: literal minus accumulator goes to accumulator
// RULE_02: file register minus accumulator, two's complement
// RULE_03: destination bit 0 writes accumulator only
// RULE_04: destination bit 1 writes file register
// RULE_05: bank bit 0 selects access bank
// RULE_06: bank bit 1 uses bank select register
// RULE_07: access, extended set, f<=95 means indexed offset
// RULE_08: both update all five status flags
// RULE_09: carry set when no borrow occurs
`default_nettype none
package sbx_pkg;
    // ---------------------------------------------------------------
    // register offsets of the plain command port
    // ---------------------------------------------------------------
    localparam logic [3:0] SBX_ADDR_CTRL = 4'h0;
    localparam logic [3:0] SBX_ADDR_ACC = 4'h1;
    localparam logic [3:0] SBX_ADDR_BANK = 4'h2;
    localparam logic [3:0] SBX_ADDR_IDX = 4'h3;
    localparam logic [3:0] SBX_ADDR_LIT = 4'h4;
    localparam logic [3:0] SBX_ADDR_FADR = 4'h5;
    localparam logic [3:0] SBX_ADDR_CMD = 4'h6;
    localparam logic [3:0] SBX_ADDR_STAT = 4'h7;
    localparam logic [3:0] SBX_ADDR_MEMD = 4'h8;
    localparam logic [3:0] SBX_ADDR_MEMA = 4'h9;
    // ---------------------------------------------------------------
    // field positions
    // ---------------------------------------------------------------
    localparam int SBX_CTRL_EXT_BIT = 0;
    localparam int SBX_CMD_OP_BIT = 0;
    localparam int SBX_CMD_D_BIT = 1;
    localparam int SBX_CMD_A_BIT = 2;
    localparam int SBX_ST_C_BIT = 0;
    localparam int SBX_ST_HALF_BIT = 1;
    localparam int SBX_ST_Z_BIT = 2;
    localparam int SBX_ST_OVF_BIT = 3;
    localparam int SBX_ST_N_BIT = 4;
    // ---------------------------------------------------------------
    // reset values and address limits
    // ---------------------------------------------------------------
    localparam logic [7:0] SBX_RST_BYTE = 8'h00;
    localparam logic [4:0] SBX_RST_FLAGS = 5'h00;
    localparam logic [3:0] SBX_RST_BANK = 4'h0;
    localparam logic [11:0] SBX_RST_ADDR = 12'h000;
    localparam logic [7:0] SBX_IDX_LIMIT = 8'h5f;
    localparam logic [7:0] SBX_ACC_SPLIT = 8'h60;
    localparam logic [3:0] SBX_SFR_BANK = 4'hf;
    typedef enum logic [1:0] {SBX_IDLE, SBX_READ, SBX_WRITE} sbx_state_e;
endpackage
`default_nettype wire

// file: tb/sbx_core_monitor.sv
// checker for the subtract datapath register port
`default_nettype none
module sbx_core_monitor
    import sbx_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic busy_ff
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    logic [7:0] acc_sh_ff;
    logic acc_ok_ff;
    wire logic cmd_go = reg_wr && !busy_ff && reg_addr == SBX_ADDR_CMD;
    wire logic st_rd = reg_rd && reg_addr == SBX_ADDR_STAT;
    // shadow of accumulator writes; void once an op may change it
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            acc_sh_ff <= 8'h00;
            acc_ok_ff <= 1'b1;
        end else if (reg_wr && !busy_ff && reg_addr == SBX_ADDR_ACC) begin
            acc_sh_ff <= reg_wdata;
            acc_ok_ff <= 1'b1;
        end else if (cmd_go) begin
            acc_ok_ff <= 1'b0;
        end
    end
    sequence lit_run;
        busy_ff ##1 !busy_ff;
    endsequence
    sequence file_run;
        busy_ff [*2] ##1 !busy_ff;
    endsequence
    lit_timing_a: assert property (cmd_go && !reg_wdata[0] |=> lit_run)
        else $error("literal op busy span wrong");
    file_timing_a: assert property (cmd_go && reg_wdata[0] |=> file_run)
        else $error("file op busy span wrong");
    busy_cause_a: assert property ($rose(busy_ff) |-> $past(cmd_go))
        else $error("busy without command");
    busy_bound_a: assert property (busy_ff ##1 busy_ff |=> !busy_ff)
        else $error("busy longer than two cycles");
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside read slot");
    acc_hold_a: assert property (reg_rd && reg_addr == SBX_ADDR_ACC && acc_ok_ff
        |=> reg_rdata == $past(acc_sh_ff))
        else $error("accumulator lost its value");
    zero_sign_a: assert property (st_rd |=> !(reg_rdata[SBX_ST_Z_BIT]
        && reg_rdata[SBX_ST_N_BIT]))
        else $error("zero result flagged negative");
    zero_carry_a: assert property (st_rd |=> !reg_rdata[SBX_ST_Z_BIT]
        || (reg_rdata[SBX_ST_C_BIT] && reg_rdata[SBX_ST_HALF_BIT]))
        else $error("zero result flagged borrow");
endmodule
bind sbx_core sbx_core_monitor i_sbx_core_monitor (.sys_clk(sys_clk), .nrst(nrst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .busy_ff(busy_ff));
`default_nettype wire

// file: tb/sbx_core_tb.sv
// self-checking bench for the subtract datapath
`default_nettype none
module sbx_core_tb
    import sbx_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic busy_ff;
    int fails = 0;
    int check_count = 0;
    sbx_core i_sbx_core (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .busy_ff(busy_ff));
    initial begin
        forever #25 sys_clk = ~sys_clk;
    end
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask
    // status as {busy, neg, ovf, zero, half, carry}; carries are inverted borrows
    function automatic logic [7:0] flg(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] r;
        r = a - b;
        return {3'b000, r[7], (a[7] != b[7]) && (r[7] != a[7]), r == 8'h00,
            a[3:0] >= b[3:0], a >= b};
    endfunction
    task automatic lit_op(input logic [7:0] k, input logic [7:0] w);
        logic [7:0] v;
        wr(SBX_ADDR_ACC, w);
        wr(SBX_ADDR_LIT, k);
        wr(SBX_ADDR_CMD, 8'h06);
        repeat (3) @(posedge sys_clk);
        rd(SBX_ADDR_ACC, v);
        chk("acc", k - w, v);
        rd(SBX_ADDR_STAT, v);
        chk("status", flg(k, w), v);
    endtask
    // preload file byte at pb:pa, run with cmd {a,d,op}, check both sides
    task automatic file_op(input logic [3:0] bank, input logic [3:0] pb, input logic [7:0] pa,
        input logic [7:0] f, input logic [2:0] cmd, input logic [7:0] m, input logic [7:0] w);
        logic [7:0] v;
        wr(SBX_ADDR_BANK, pb);
        wr(SBX_ADDR_MEMA, pa);
        wr(SBX_ADDR_MEMD, m);
        wr(SBX_ADDR_BANK, bank);
        wr(SBX_ADDR_ACC, w);
        wr(SBX_ADDR_FADR, f);
        wr(SBX_ADDR_CMD, {5'h00, cmd});
        repeat (4) @(posedge sys_clk);
        rd(SBX_ADDR_ACC, v);
        chk("acc", cmd[1] ? w : m - w, v);
        rd(SBX_ADDR_STAT, v);
        chk("status", flg(m, w), v);
        wr(SBX_ADDR_BANK, pb);
        wr(SBX_ADDR_MEMA, pa);
        rd(SBX_ADDR_MEMD, v);
        chk("file", cmd[1] ? m - w : m, v);
    endtask
    task automatic test_lit();
        lit_op(8'h02, 8'h01);
        lit_op(8'h02, 8'h02);
        lit_op(8'h02, 8'h03);
        lit_op(8'h80, 8'h01);
        lit_op(8'h10, 8'h01);
        $display("test literal done");
    endtask
    task automatic test_banks();
        wr(SBX_ADDR_CTRL, 8'h00);
        file_op(4'h2, 4'h2, 8'h10, 8'h10, 3'b101, 8'h05, 8'h07);
        file_op(4'h2, 4'h2, 8'h10, 8'h10, 3'b111, 8'h33, 8'h11);
        file_op(4'h3, 4'h0, 8'h20, 8'h20, 3'b011, 8'h09, 8'h04);
        file_op(4'h3, 4'hf, 8'h80, 8'h80, 3'b011, 8'h01, 8'h02);
        $display("test banks done");
    endtask
    task automatic test_index();
        wr(SBX_ADDR_CTRL, 8'h01);
        wr(SBX_ADDR_IDX, 8'h40);
        file_op(4'h3, 4'h0, 8'h45, 8'h05, 3'b011, 8'h20, 8'h08);
        file_op(4'h3, 4'h0, 8'h9f, 8'h5f, 3'b011, 8'h7f, 8'h80);
        file_op(4'h3, 4'hf, 8'h60, 8'h60, 3'b001, 8'h44, 8'h40);
        file_op(4'h2, 4'h2, 8'h05, 8'h05, 3'b111, 8'h50, 8'h10);
        wr(SBX_ADDR_CTRL, 8'h00);
        $display("test index done");
    endtask
    // a write landing while busy must be dropped
    task automatic test_refuse();
        logic [7:0] v;
        wr(SBX_ADDR_ACC, 8'h10);
        rd(SBX_ADDR_ACC, v);
        chk("acc", 8'h10, v);
        wr(SBX_ADDR_LIT, 8'h30);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= SBX_ADDR_CMD;
        reg_wdata <= 8'h06;
        @(posedge sys_clk);
        reg_addr <= SBX_ADDR_ACC;
        reg_wdata <= 8'h77;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rd(SBX_ADDR_ACC, v);
        chk("acc", 8'h20, v);
        $display("test refuse done");
    endtask
    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        #200000;
        fails++;
        end_of_test();
    end
    initial begin
        repeat (4) @(posedge sys_clk);
        nrst <= 1'b1;
        test_lit();
        test_banks();
        test_index();
        test_refuse();
        end_of_test();
    end
endmodule
`default_nettype wire
